// File: verilog/flwp_defs.vh
// Constants for the single-word flash program sequencer.
// Included by every design file of the block; definitions only.
`ifndef FLWP_DEFS_VH
`define FLWP_DEFS_VH

// APB byte addresses of the registers
`define FLWP_ADDR_W          12
`define FLWP_OFF_CTRL        12'h000
`define FLWP_OFF_KEY         12'h004
`define FLWP_OFF_PAGE        12'h008
`define FLWP_OFF_TWL         12'h00C
`define FLWP_OFF_TWH         12'h010

// Control register fields
`define FLWP_OP_MSB          3
`define FLWP_OP_LSB          0
`define FLWP_BIT_ERR         13
`define FLWP_BIT_WREN        14
`define FLWP_BIT_START       15
`define FLWP_OP_ONE_WORD     4'h3
`define FLWP_OP_RST          4'h0

// Unlock key values
`define FLWP_KEY_FIRST       8'h55
`define FLWP_KEY_SECOND      8'hAA
`define FLWP_KEY_W           8

// Widths and field positions of the latch
`define FLWP_WORD_W          24
`define FLWP_PAGE_W          8
`define FLWP_OFFS_W          16
`define FLWP_LOW_W           16
`define FLWP_HIGH_W          8
`define FLWP_OFFS_MSB        31
`define FLWP_OFFS_LSB        16

// Unlock sequencer states
`define FLWP_UK_IDLE         2'h0
`define FLWP_UK_FIRST        2'h1
`define FLWP_UK_ARMED        2'h2

`endif

// File: verilog/flwp_wlatch.v
// Write latch: one 24-bit instruction word and its target address.
// Fed by the table-write low/high strobes of the register front end.
`timescale 1ns/1ps
`default_nettype none
`include "flwp_defs.vh"

module flwp_wlatch (
    input  wire                     i_clk,
    input  wire                     i_rst_n,
    input  wire                     i_wr_low,
    input  wire                     i_wr_high,
    input  wire [`FLWP_PAGE_W-1:0]  i_page,
    input  wire [`FLWP_OFFS_W-1:0]  i_offset,
    input  wire [`FLWP_LOW_W-1:0]   i_data,
    output reg  [`FLWP_WORD_W-1:0]  o_addr,
    output reg  [`FLWP_WORD_W-1:0]  o_word
);

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_addr <= {`FLWP_WORD_W{1'b0}};
            o_word <= {`FLWP_WORD_W{1'b0}};
        end else begin
            // Page gives the upper byte, the write operand the lower 16 bits
            if (i_wr_low || i_wr_high) begin
                o_addr <= {i_page, i_offset};
            end
            // Both halves land in the same latch word
            if (i_wr_low) begin
                o_word[`FLWP_LOW_W-1:0] <= i_data;
            end
            if (i_wr_high) begin
                o_word[`FLWP_WORD_W-1:`FLWP_LOW_W] <= i_data[`FLWP_HIGH_W-1:0];
            end
        end
    end

endmodule // flwp_wlatch
`default_nettype wire

// File: verilog/flwp_unlock.v
// Unlock key tracker: arms only after 0x55 then 0xAA as back-to-back writes.
// Assumes one i_any_wr pulse per completed register write.
`timescale 1ns/1ps
`default_nettype none
`include "flwp_defs.vh"

module flwp_unlock (
    input  wire        i_clk,
    input  wire        i_rst_n,
    input  wire        i_any_wr,
    input  wire        i_key_wr,
    input  wire [`FLWP_KEY_W-1:0] i_key_data,
    output wire        o_armed
);

    reg [1:0] state_q;
    reg [1:0] state_d;

    assign o_armed = (state_q == `FLWP_UK_ARMED);

    // Any other write in between drops the sequence
    always @* begin
        state_d = state_q;
        if (i_any_wr) begin
            state_d = `FLWP_UK_IDLE;
            if (i_key_wr) begin
                case (state_q)
                    `FLWP_UK_FIRST: begin
                        if (i_key_data == `FLWP_KEY_SECOND) begin
                            state_d = `FLWP_UK_ARMED;
                        end else if (i_key_data == `FLWP_KEY_FIRST) begin
                            state_d = `FLWP_UK_FIRST;
                        end
                    end
                    default: begin
                        if (i_key_data == `FLWP_KEY_FIRST) begin
                            state_d = `FLWP_UK_FIRST;
                        end
                    end
                endcase
            end
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= `FLWP_UK_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

endmodule // flwp_unlock
`default_nettype wire

// File: verilog/flwp_top.v
// Single-word flash program sequencer with an APB register front end.
// Assumes a flash array macro that takes one program pulse and returns a
// done pulse; APB master follows the standard two-phase protocol.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "flwp_defs.vh"

module flwp_top (
    input  wire                      I_CLOCK,
    input  wire                      I_RST_N,
    input  wire                      I_PSEL,
    input  wire                      I_PENABLE,
    input  wire                      I_PWRITE,
    input  wire [`FLWP_ADDR_W-1:0]   I_PADDR,
    input  wire [31:0]               I_PWDATA,
    input  wire                      I_FLASH_DONE,
    output wire                      O_PREADY,
    output reg  [31:0]               O_PRDATA,
    output wire                      O_PSLVERR,
    output reg                       O_FLASH_PROG,
    output reg  [`FLWP_WORD_W-1:0]   O_FLASH_ADDR,
    output reg  [`FLWP_WORD_W-1:0]   O_FLASH_DATA
);

    wire                     access;
    wire                     wr_done;
    wire                     mapped;
    wire                     wr_ctrl;
    wire                     wr_key;
    wire                     wr_page;
    wire                     wr_low;
    wire                     wr_high;
    wire                     armed;
    wire                     start_req;
    wire                     start_ok;
    wire [`FLWP_WORD_W-1:0]  latch_addr;
    wire [`FLWP_WORD_W-1:0]  latch_word;

    reg  [`FLWP_OP_MSB:`FLWP_OP_LSB] op_q;
    reg                      wren_q;
    reg                      err_q;
    reg                      busy_q;
    reg  [`FLWP_PAGE_W-1:0]  page_q;
    reg  [31:0]              rdata_d;

    // Zero-wait slave: every access completes in its first access cycle
    assign access   = I_PSEL && I_PENABLE;
    assign O_PREADY = 1'b1;
    assign mapped   = (I_PADDR == `FLWP_OFF_CTRL) || (I_PADDR == `FLWP_OFF_KEY) ||
                      (I_PADDR == `FLWP_OFF_PAGE) || (I_PADDR == `FLWP_OFF_TWL) ||
                      (I_PADDR == `FLWP_OFF_TWH);
    assign O_PSLVERR = access && !mapped;
    assign wr_done   = access && I_PWRITE;
    assign wr_ctrl   = wr_done && (I_PADDR == `FLWP_OFF_CTRL);
    assign wr_key    = wr_done && (I_PADDR == `FLWP_OFF_KEY);
    assign wr_page   = wr_done && (I_PADDR == `FLWP_OFF_PAGE);
    // Table writes while a cycle runs would corrupt the word being programmed
    assign wr_low    = wr_done && (I_PADDR == `FLWP_OFF_TWL) && !busy_q;
    assign wr_high   = wr_done && (I_PADDR == `FLWP_OFF_TWH) && !busy_q;

    // Start needs the armed key, enable set and the one-word operation
    assign start_req = wr_ctrl && I_PWDATA[`FLWP_BIT_START] && !busy_q;
    assign start_ok  = start_req && armed && I_PWDATA[`FLWP_BIT_WREN] &&
                       (I_PWDATA[`FLWP_OP_MSB:`FLWP_OP_LSB] == `FLWP_OP_ONE_WORD);

    flwp_unlock u_unlock (
        .i_clk      (I_CLOCK),
        .i_rst_n    (I_RST_N),
        .i_any_wr   (wr_done),
        .i_key_wr   (wr_key),
        .i_key_data (I_PWDATA[`FLWP_KEY_W-1:0]),
        .o_armed    (armed)
    );

    flwp_wlatch u_wlatch (
        .i_clk      (I_CLOCK),
        .i_rst_n    (I_RST_N),
        .i_wr_low   (wr_low),
        .i_wr_high  (wr_high),
        .i_page     (page_q),
        .i_offset   (I_PWDATA[`FLWP_OFFS_MSB:`FLWP_OFFS_LSB]),
        .i_data     (I_PWDATA[`FLWP_LOW_W-1:0]),
        .o_addr     (latch_addr),
        .o_word     (latch_word)
    );

    // Control, page and program sequencing
    always @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            op_q         <= `FLWP_OP_RST;
            wren_q       <= 1'b0;
            err_q        <= 1'b0;
            busy_q       <= 1'b0;
            page_q       <= {`FLWP_PAGE_W{1'b0}};
            O_FLASH_PROG <= 1'b0;
            O_FLASH_ADDR <= {`FLWP_WORD_W{1'b0}};
            O_FLASH_DATA <= {`FLWP_WORD_W{1'b0}};
        end else begin
            O_FLASH_PROG <= 1'b0;
            if (wr_page) begin
                page_q <= I_PWDATA[`FLWP_PAGE_W-1:0];
            end
            // Control fields are frozen while a cycle runs, page writes are not
            if (wr_ctrl && !busy_q) begin
                op_q   <= I_PWDATA[`FLWP_OP_MSB:`FLWP_OP_LSB];
                wren_q <= I_PWDATA[`FLWP_BIT_WREN];
                err_q  <= I_PWDATA[`FLWP_BIT_ERR] & err_q;
            end
            if (start_ok) begin
                busy_q       <= 1'b1;
                err_q        <= 1'b0;
                O_FLASH_PROG <= 1'b1;
                O_FLASH_ADDR <= latch_addr;
                O_FLASH_DATA <= latch_word;
            end else if (start_req) begin
                // Refused start: flag it, start bit stays clear
                err_q <= 1'b1;
            end else if (busy_q && I_FLASH_DONE) begin
                busy_q <= 1'b0;
            end
        end
    end

    always @* begin
        rdata_d = 32'h0000_0000;
        case (I_PADDR)
            `FLWP_OFF_CTRL: begin
                rdata_d[`FLWP_OP_MSB:`FLWP_OP_LSB] = op_q;
                rdata_d[`FLWP_BIT_ERR]             = err_q;
                rdata_d[`FLWP_BIT_WREN]            = wren_q;
                rdata_d[`FLWP_BIT_START]           = busy_q;
            end
            `FLWP_OFF_PAGE: begin
                rdata_d[`FLWP_PAGE_W-1:0] = page_q;
            end
            `FLWP_OFF_TWL: begin
                rdata_d[`FLWP_LOW_W-1:0] = latch_word[`FLWP_LOW_W-1:0];
            end
            `FLWP_OFF_TWH: begin
                rdata_d[`FLWP_HIGH_W-1:0] = latch_word[`FLWP_WORD_W-1:`FLWP_LOW_W];
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // Read data registered in the setup cycle, valid in the access cycle
    always @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_PRDATA <= 32'h0000_0000;
        end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            O_PRDATA <= rdata_d;
        end
    end

endmodule // flwp_top
`default_nettype wire

// File: tb/flwp_asserts.sv
// Port checker of the flash program sequencer.
// Bound to flwp_top; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "flwp_defs.vh"
module flwp_asserts (
    input wire logic                    I_CLOCK,
    input wire logic                    I_RST_N,
    input wire logic                    I_PSEL,
    input wire logic                    I_PENABLE,
    input wire logic                    I_PWRITE,
    input wire logic [`FLWP_ADDR_W-1:0] I_PADDR,
    input wire logic [31:0]             I_PWDATA,
    input wire logic                    I_FLASH_DONE,
    input wire logic                    O_PREADY,
    input wire logic [31:0]             O_PRDATA,
    input wire logic                    O_PSLVERR,
    input wire logic                    O_FLASH_PROG,
    input wire logic [23:0]             O_FLASH_ADDR,
    input wire logic [23:0]             O_FLASH_DATA
);
    logic k55_q, pair_q, busy_q;
    wire acs = I_PSEL && I_PENABLE;
    wire wr = acs && I_PWRITE && O_PREADY;
    wire kw = wr && I_PADDR == `FLWP_OFF_KEY;
    wire rdc = acs && !I_PWRITE && I_PADDR == `FLWP_OFF_CTRL;
    wire map = I_PADDR inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
    // Any write between key and start breaks the pair, reads do not
    wire acc = wr && !busy_q && pair_q && I_PADDR == `FLWP_OFF_CTRL
        && I_PWDATA[15:14] == 2'b11 && I_PWDATA[3:0] == `FLWP_OP_ONE_WORD;
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            k55_q <= 1'b0;
            pair_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            if (wr) k55_q <= kw && I_PWDATA[7:0] == 8'h55;
            if (wr) pair_q <= kw && I_PWDATA[7:0] == 8'hAA && k55_q;
            if (acc) busy_q <= 1'b1;
            else if (I_FLASH_DONE) busy_q <= 1'b0;
        end
    end
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    chk_prog_start: assert property (O_FLASH_PROG == $past(acc))
        else $error("program strobe without accepted start");
    chk_prog_pulse: assert property (O_FLASH_PROG |=> !O_FLASH_PROG)
        else $error("program strobe longer than one cycle");
    chk_key_pair: assert property (O_FLASH_PROG |-> $past(pair_q))
        else $error("program without key pair");
    chk_word_hold: assert property ($changed(O_FLASH_DATA) |-> O_FLASH_PROG)
        else $error("word changed outside start");
    chk_addr_hold: assert property ($changed(O_FLASH_ADDR) |-> O_FLASH_PROG)
        else $error("address changed outside start");
    chk_busy_read: assert property (rdc |-> O_PRDATA[15] == $past(busy_q))
        else $error("start bit read wrong");
    chk_key_read: assert property (acs && !I_PWRITE && I_PADDR == `FLWP_OFF_KEY |-> O_PRDATA == 0)
        else $error("key register not read as zero");
    chk_err_resp: assert property (O_PREADY && O_PSLVERR == (acs && !map))
        else $error("ready or error response wrong");
    cover property (O_FLASH_PROG);
    cover property (rdc && busy_q);
    cover property (O_PSLVERR);
endmodule // flwp_asserts
bind flwp_top flwp_asserts chk_u (.I_CLOCK, .I_RST_N, .I_PSEL, .I_PENABLE, .I_PWRITE,
    .I_PADDR, .I_PWDATA, .I_FLASH_DONE, .O_PREADY, .O_PRDATA, .O_PSLVERR, .O_FLASH_PROG,
    .O_FLASH_ADDR, .O_FLASH_DATA);
`default_nettype wire

// File: tb/flash_word_program_sequencer_bench.sv
// Self-checking bench of the flash program sequencer over APB.
// Bench drives every port; the flash array is a done pulse it gives.
`timescale 1ns/1ps
`default_nettype none
`include "flwp_defs.vh"
module flash_word_program_sequencer_bench;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, done = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic        slv;
    wire         rdy, err, prog;
    wire  [31:0] prdata;
    wire  [23:0] faddr, fdata;
    integer n_errors = 0, cmp_count = 0, seed = 32'h66E2, nprog = 0, i, pg, of, lw, hb;
    // Model: one queued {address, word} per start that the rules accept
    logic [47:0] exp_q[$];
    always #10 clk = ~clk;
    flwp_top dut_u (.I_CLOCK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_FLASH_DONE(done),
        .O_PREADY(rdy), .O_PRDATA(prdata), .O_PSLVERR(err), .O_FLASH_PROG(prog),
        .O_FLASH_ADDR(faddr), .O_FLASH_DATA(fdata));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Every strobe must match the oldest accepted start of the model
    always @(posedge clk) begin
        if (prog === 1'b1) begin
            nprog <= nprog + 1;
            chk("queued start", 32'h1, {31'h0, exp_q.size() > 0});
            if (exp_q.size() > 0) begin
                chk("model addr", {8'h00, exp_q[0][47:24]}, faddr);
                chk("model word", {8'h00, exp_q[0][23:0]}, fdata);
                exp_q.delete(0);
            end
        end
    end
    // Idle cycle first so no signal is assigned twice in one time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        rd = prdata;
        slv = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic arm(input logic [7:0] k1, k2, input logic mid, input logic [31:0] st);
        apb(1'b1, `FLWP_OFF_CTRL, 32'h4003);
        // Keys and start go back to back, except that mid puts a page write between the two keys
        apb(1'b1, `FLWP_OFF_KEY, {24'h0, k1});
        if (mid) apb(1'b1, `FLWP_OFF_PAGE, pg);
        apb(1'b1, `FLWP_OFF_KEY, {24'h0, k2});
        apb(1'b1, `FLWP_OFF_CTRL, st);
        repeat (2) @(posedge clk);
        apb(1'b0, `FLWP_OFF_CTRL, 32'h0);
    endtask
    task automatic results;
        if (n_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        results;
    end
    initial begin
        pg = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, `FLWP_OFF_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, 12'hFFC, 32'h0);
        chk("unmapped", 32'h8000_0000, {slv, rd[30:0]});
        // Wrong order, a write between keys, wrong op, write enable off
        for (i = 0; i < 4; i++) begin
            arm(i == 0 ? 8'hAA : 8'h55, i == 0 ? 8'h55 : 8'hAA, i == 1,
                i == 2 ? 32'hC002 : (i == 3 ? 32'h8003 : 32'hC003));
            chk("refused start", 32'h2000, rd & 32'hA000);
        end
        for (i = 0; i < 3; i++) begin
            pg = $random(seed) & 255;
            // Distinct offsets, so every target is still erased
            of = ($random(seed) & 65532) | i;
            lw = $random(seed) & 65535;
            hb = $random(seed) & 255;
            apb(1'b1, `FLWP_OFF_PAGE, pg);
            apb(1'b1, `FLWP_OFF_TWL, {of[15:0], lw[15:0]});
            apb(1'b1, `FLWP_OFF_TWH, {of[15:0], 8'h00, hb[7:0]});
            exp_q.push_back({pg[7:0], of[15:0], hb[7:0], lw[15:0]});
            arm(8'h55, 8'hAA, 1'b0, 32'hC003);
            chk("addr", {8'h0, pg[7:0], of[15:0]}, faddr);
            chk("word", {8'h0, hb[7:0], lw[15:0]}, fdata);
            chk("busy", 32'h8003, rd & 32'hA00F);
            apb(1'b1, `FLWP_OFF_TWL, ~lw);
            done <= 1'b1;
            @(posedge clk);
            done <= 1'b0;
            apb(1'b0, `FLWP_OFF_CTRL, 32'h0);
            chk("idle", 32'h3, rd & 32'hA00F);
            apb(1'b0, `FLWP_OFF_TWL, 32'h0);
            chk("latch low", lw & 32'hFFFF, rd);
        end
        chk("strobes", 32'h3, nprog);
        chk("queue drained", 32'h0, exp_q.size());
        results;
    end
endmodule // flash_word_program_sequencer_bench
`default_nettype wire
